//--- hdl/logical_device_config_bank.sv
// index/data port decoder, unit select and power gating of the unit banks
`timescale 1ns/1ps
// How it works
// - one bank per unit, chosen by 0x07
// - index port picks register, data port moves it
// - config state only, except unit 7 0x82-0x9A
// - 0x30 bit 0 activates selected unit
// - 0x31-0x3F ignore writes, read zero
// - 0x40-0x5F ignore writes, read zero
// - 0x60 base high byte, 0x61 low byte
// - other 0x62-0x6F ignore writes, read zero
// - 0x70 everywhere, 0x72 keyboard unit only
// - interrupts default edge-triggered active high
// - 0x71, 0x73, 0x76-0xDF read zero
// - 0x74 floppy and parallel only; 0x75 zero
// - on needs activate, power and override set
// - activate and power bits mirror each other
// - override bits seven, six, four: units 3,4,0
// - cleared override forces unit off
// - out-of-range base makes unit decode invalid, except units 6 and 7
// - 0x22 holds power bits 0,3,4,5
module logical_device_config_bank
  import ldcfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic cfg_state_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic io_data_sel_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] ec_disable_i,
  output logic [7:0] io_rdata_o,
  output logic [NUM_UNITS-1:0] unit_on_o,
  output logic [NUM_UNITS-1:0] decode_en_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic unit_present(input logic [2:0] u);
    return (u != 3'h1) && (u != 3'h2);
  endfunction : unit_present

  function automatic logic in_span(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_span

  // units 6 and 7 sit at fixed addresses, so their base never disqualifies them
  function automatic logic base_ok(input logic [2:0] u, input logic [15:0] a);
    logic ok;
    ok = 1'b0;
    if (u == PARALLEL_UNIT) begin
      ok = (a >= BASE_MIN) && (a <= BASE_MAX_4B) && (a[1:0] == 2'h0);
    end else if ((u == FLOPPY_UNIT) || (u == SERIAL1_UNIT) || (u == SERIAL2_UNIT)) begin
      ok = (a >= BASE_MIN) && (a <= BASE_MAX_8B) && (a[2:0] == 3'h0);
    end else if ((u == RTC_UNIT) || (u == KEYBOARD_CTRL_UNIT)) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : base_ok

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] index_reg;
  logic [7:0] unit_sel_reg;
  logic [7:0] rdata_next;
  logic [NUM_UNITS-1:0] unit_on_next;
  logic [NUM_UNITS-1:0] decode_en_next;
  logic [NUM_UNITS-1:0] override_ok;

  bank_if bif ();

  unit_bank_store u_store (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .bif(bif)
  );

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire logic [2:0] sel_unit = unit_sel_reg[2:0];
  wire logic sel_valid = (unit_sel_reg[7:3] == 5'h00) && unit_present(sel_unit);
  wire logic idx_wr = io_wr_i && !io_data_sel_i;
  wire logic dat_wr = io_wr_i && io_data_sel_i;
  wire logic dat_rd = io_rd_i && io_data_sel_i;
  wire logic chip_space = (index_reg < IDX_BANK_LO);
  wire logic run_window = (sel_unit == KEYBOARD_CTRL_UNIT) && sel_valid &&
                          in_span(index_reg, IDX_RUN_LO, IDX_RUN_HI);
  wire logic bank_ok = !chip_space && sel_valid &&
                       (cfg_state_i || run_window);
  wire logic chip_ok = chip_space && cfg_state_i;
  wire logic unit_sel_hit = chip_ok && (index_reg == IDX_UNIT_SEL);
  wire logic pwr_hit = chip_ok && (index_reg == IDX_PWR_CTRL);

  // only implemented indices map to a field; all others fall through to zero
  field_t fld;
  assign fld = !bank_ok ? FLD_NONE :
               (index_reg == IDX_ACTIVATE) ? FLD_ACT :
               (index_reg == IDX_BASE_HI) ? FLD_BASE_HI :
               (index_reg == IDX_BASE_LO) ? FLD_BASE_LO :
               (index_reg == IDX_IRQ_PRI) ? FLD_IRQ_PRI :
               (index_reg == IDX_IRQ_SEC) ? FLD_IRQ_SEC :
               (index_reg == IDX_DMA_SEL) ? FLD_DMA :
               FLD_NONE;

  assign bif.wr_en = dat_wr && (fld != FLD_NONE);
  assign bif.wr_unit = sel_unit;
  assign bif.wr_field = fld;
  assign bif.wr_data = io_wdata_i;
  assign bif.pwr_wr = dat_wr && pwr_hit;
  assign bif.pwr_data = io_wdata_i;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire logic [7:0] pwr_view = {2'h0, bif.act[SERIAL2_UNIT], bif.act[SERIAL1_UNIT],
                               bif.act[PARALLEL_UNIT], 2'h0, bif.act[FLOPPY_UNIT]};
  wire logic [7:0] act_view = {7'h00, bif.act[sel_unit]};

  always_comb begin
    rdata_next = 8'h00;
    if (!io_data_sel_i) begin
      rdata_next = index_reg;
    end else if (unit_sel_hit) begin
      rdata_next = unit_sel_reg;
    end else if (pwr_hit) begin
      rdata_next = pwr_view;
    end else begin
      unique case (fld)
        FLD_ACT: rdata_next = act_view;
        FLD_BASE_HI: rdata_next = bif.base_hi[sel_unit];
        FLD_BASE_LO: rdata_next = bif.base_lo[sel_unit];
        FLD_IRQ_PRI: rdata_next = bif.irq_pri[sel_unit];
        FLD_IRQ_SEC: rdata_next = bif.irq_sec[sel_unit];
        FLD_DMA: rdata_next = bif.dma[sel_unit];
        FLD_NONE: rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // override input synchroniser
  // ----------------------------------------------------------------
  // the disable register sits in the embedded controller's clock domain;
  // a bit change counts only once the second and third stages agree
  logic [7:0] ec_meta_reg;
  logic [7:0] ec_s2_reg;
  logic [7:0] ec_s3_reg;
  logic [7:0] ec_stable_reg;
  wire logic [7:0] ec_agree = ~(ec_s2_reg ^ ec_s3_reg);
  wire logic [7:0] ec_stable_next = (ec_s2_reg & ec_agree) | (ec_stable_reg & ~ec_agree);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ec_meta_reg <= EC_DISABLE_RST;
      ec_s2_reg <= EC_DISABLE_RST;
      ec_s3_reg <= EC_DISABLE_RST;
    end else begin
      ec_meta_reg <= ec_disable_i;
      ec_s2_reg <= ec_meta_reg;
      ec_s3_reg <= ec_s2_reg;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ec_stable_reg <= EC_DISABLE_RST;
    end else begin
      ec_stable_reg <= ec_stable_next;
    end
  end

  // ----------------------------------------------------------------
  // power gating and address qualification
  // ----------------------------------------------------------------
  always_comb begin
    override_ok = '1;
    override_ok[PARALLEL_UNIT] = ec_stable_reg[OVERRIDE_BIT_SEVEN];
    override_ok[SERIAL1_UNIT] = ec_stable_reg[OVERRIDE_BIT_SIX];
    override_ok[FLOPPY_UNIT] = ec_stable_reg[OVERRIDE_BIT_FOUR];
  end

  // the shared enable bit stands for both activate and power terms
  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      unit_on_next[u] = unit_present(u[2:0]) && bif.act[u] && override_ok[u];
      decode_en_next[u] = unit_on_next[u] &&
                          base_ok(u[2:0], {bif.base_hi[u], bif.base_lo[u]});
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // index writes are taken in either state so the run-state window is reachable
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      index_reg <= INDEX_RST;
    end else if (idx_wr) begin
      index_reg <= io_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      unit_sel_reg <= UNIT_SEL_RST;
    end else if (dat_wr && unit_sel_hit) begin
      unit_sel_reg <= io_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      io_rdata_o <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      unit_on_o <= '0;
      decode_en_o <= '0;
    end else begin
      unit_on_o <= unit_on_next;
      decode_en_o <= decode_en_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  floppy_on_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    unit_on_o[0] == $past(bif.act[0] && ec_stable_reg[OVERRIDE_BIT_FOUR]))
    else $error("floppy unit power state wrong");

  override_off_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !ec_stable_reg[OVERRIDE_BIT_SEVEN] |=> !unit_on_o[3])
    else $error("parallel unit on while override cleared");

  serial_ovr_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (bif.act[4] && !ec_stable_reg[OVERRIDE_BIT_SIX]) ##1 ec_stable_reg[OVERRIDE_BIT_SIX]
    && bif.act[4] |=> unit_on_o[4])
    else $error("serial unit override mapping wrong");

  power_link_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_wr && pwr_hit) |=> bif.act[3] == $past(io_wdata_i[3]))
    else $error("power bit did not follow to activate");

  run_block_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_wr && !cfg_state_i) |-> !bif.wr_en && !bif.pwr_wr)
    else $error("bank written outside configuration state");

  reserved_zero_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_rd && in_span(index_reg, 8'h31, 8'h5F)) |=> io_rdata_o == 8'h00)
    else $error("reserved index read nonzero");

  base_write_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_wr && cfg_state_i && sel_valid && index_reg == IDX_BASE_HI) |=>
    bif.base_hi[$past(sel_unit)] == $past(io_wdata_i))
    else $error("base high byte not stored");

  irq_sec_only_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    bif.irq_sec[0] == 8'h00 && bif.irq_sec[6] == 8'h00)
    else $error("second interrupt select stored off keyboard unit");

  dma_only_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    bif.dma[4] == 8'h00 && bif.dma[7] == 8'h00)
    else $error("dma select stored on unit without it");

  base_range_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    decode_en_o[3] |-> $past(bif.base_hi[3]) <= 8'h0F && $past(bif.base_hi[3]) >= 8'h01
    && $past(bif.base_lo[3][1:0]) == 2'h0)
    else $error("parallel decode enabled with illegal base");

  idx_read_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (io_rd_i && !io_data_sel_i) |=> io_rdata_o == $past(index_reg))
    else $error("index port read did not return the index");

  unit_sel_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_wr && unit_sel_hit) |=> unit_sel_reg == $past(io_wdata_i))
    else $error("unit select not stored");

  act_write_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (bif.wr_en && bif.wr_field == FLD_ACT) |=>
    bif.act[$past(sel_unit)] == $past(bif.wr_data[ACT_BIT]))
    else $error("activate bit not stored");

  base_gap_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_rd && in_span(index_reg, 8'h62, 8'h6F)) |=> io_rdata_o == 8'h00)
    else $error("unused base index read nonzero");

  upper_zero_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_rd && (index_reg == 8'h71 || index_reg == 8'h73 ||
    in_span(index_reg, 8'h76, 8'hDF))) |=> io_rdata_o == 8'h00)
    else $error("unimplemented index read nonzero");

  dma_gap_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_rd && index_reg == 8'h75) |=> io_rdata_o == 8'h00)
    else $error("second dma index read nonzero");

  pwr_read_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_rd && pwr_hit) |=> io_rdata_o[0] == $past(bif.act[FLOPPY_UNIT]) &&
    io_rdata_o[7:6] == 2'h0 && io_rdata_o[2:1] == 2'h0)
    else $error("power register read wrong");

  serial_off_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !ec_stable_reg[OVERRIDE_BIT_SIX] |=> !unit_on_o[SERIAL1_UNIT])
    else $error("serial unit on while override cleared");

  run_sel_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_wr && !cfg_state_i) |=> unit_sel_reg == $past(unit_sel_reg))
    else $error("unit select written outside configuration state");

  ec_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (ec_s2_reg[OVERRIDE_BIT_FOUR] != ec_s3_reg[OVERRIDE_BIT_FOUR]) |=>
    $stable(ec_stable_reg[OVERRIDE_BIT_FOUR]))
    else $error("override bit taken before stages agreed");

  unit_on_c: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) unit_on_o[0]);
  run_win_c: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    dat_rd && run_window && !cfg_state_i);
  decode_c: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) decode_en_o[4]);
  pwr_c: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) dat_wr && pwr_hit);
  run_wr_c: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    dat_wr && !cfg_state_i);
endmodule : logical_device_config_bank

//--- pkg/ldcfg_pkg.sv
// package: offsets, field layouts, reset values and unit numbers of the unit bank
package ldcfg_pkg;
  // ----------------------------------------------------------------
  // chip-level indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_UNIT_SEL = 8'h07;
  localparam logic [7:0] IDX_PWR_CTRL = 8'h22;
  localparam logic [7:0] IDX_BANK_LO = 8'h30;
  // ----------------------------------------------------------------
  // per-unit bank indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_IRQ_PRI = 8'h70;
  localparam logic [7:0] IDX_IRQ_SEC = 8'h72;
  localparam logic [7:0] IDX_DMA_SEL = 8'h74;
  localparam logic [7:0] IDX_RUN_LO = 8'h82;
  localparam logic [7:0] IDX_RUN_HI = 8'h9A;
  // ----------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------
  localparam int ACT_BIT = 0;
  localparam logic [7:0] PWR_MASK = 8'h39;
  localparam int OVERRIDE_BIT_SEVEN = 7;
  localparam int OVERRIDE_BIT_SIX = 6;
  localparam int OVERRIDE_BIT_FOUR = 4;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] UNIT_SEL_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [7:0] BASE_RST = 8'h00;
  // zero selects a channel with edge-triggered, active-high signalling
  localparam logic [7:0] IRQ_SEL_RST = 8'h00;
  localparam logic [7:0] DMA_SEL_RST = 8'h00;
  localparam logic [7:0] EC_DISABLE_RST = 8'h00;
  // ----------------------------------------------------------------
  // unit numbers and permitted base ranges
  // ----------------------------------------------------------------
  localparam logic [2:0] FLOPPY_UNIT = 3'h0;
  localparam logic [2:0] PARALLEL_UNIT = 3'h3;
  localparam logic [2:0] SERIAL1_UNIT = 3'h4;
  localparam logic [2:0] SERIAL2_UNIT = 3'h5;
  localparam logic [2:0] RTC_UNIT = 3'h6;
  localparam logic [2:0] KEYBOARD_CTRL_UNIT = 3'h7;
  localparam int NUM_UNITS = 8;
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] BASE_MAX_8B = 16'h0FF8;
  localparam logic [15:0] BASE_MAX_4B = 16'h0FFC;

  typedef enum {
    FLD_NONE,
    FLD_ACT,
    FLD_BASE_HI,
    FLD_BASE_LO,
    FLD_IRQ_PRI,
    FLD_IRQ_SEC,
    FLD_DMA
  } field_t;
endpackage : ldcfg_pkg

//--- pkg/bank_if.sv
// interface between the index/data decoder and the per-unit register store
`timescale 1ns/1ps
interface bank_if;
  import ldcfg_pkg::*;
  logic wr_en;
  logic [2:0] wr_unit;
  field_t wr_field;
  logic [7:0] wr_data;
  logic pwr_wr;
  logic [7:0] pwr_data;
  logic [NUM_UNITS-1:0] act;
  logic [7:0] base_hi [NUM_UNITS];
  logic [7:0] base_lo [NUM_UNITS];
  logic [7:0] irq_pri [NUM_UNITS];
  logic [7:0] irq_sec [NUM_UNITS];
  logic [7:0] dma [NUM_UNITS];

  modport store (
    input wr_en, wr_unit, wr_field, wr_data, pwr_wr, pwr_data,
    output act, base_hi, base_lo, irq_pri, irq_sec, dma
  );
  modport ctrl (
    output wr_en, wr_unit, wr_field, wr_data, pwr_wr, pwr_data,
    input act, base_hi, base_lo, irq_pri, irq_sec, dma
  );
endinterface : bank_if

//--- hdl/unit_bank_store.sv
// per-unit register store: one bank of configuration bytes for each unit
`timescale 1ns/1ps
module unit_bank_store
  import ldcfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  bank_if.store bif
);
  // ----------------------------------------------------------------
  // write enables per field
  // ----------------------------------------------------------------
  wire logic wr_act = bif.wr_en && (bif.wr_field == FLD_ACT);
  wire logic wr_bhi = bif.wr_en && (bif.wr_field == FLD_BASE_HI);
  wire logic wr_blo = bif.wr_en && (bif.wr_field == FLD_BASE_LO);
  wire logic wr_ip = bif.wr_en && (bif.wr_field == FLD_IRQ_PRI);
  // second interrupt select only on the keyboard controller unit
  wire logic wr_is = bif.wr_en && (bif.wr_field == FLD_IRQ_SEC) &&
                     (bif.wr_unit == KEYBOARD_CTRL_UNIT);
  // dma select only on the floppy and parallel units
  wire logic wr_dma = bif.wr_en && (bif.wr_field == FLD_DMA) &&
                      ((bif.wr_unit == FLOPPY_UNIT) ||
                       (bif.wr_unit == PARALLEL_UNIT));

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // one enable bit serves as both activate and power bit, so they cannot drift
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bif.act <= '0;
    end else begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (wr_act && (bif.wr_unit == u[2:0])) begin
          bif.act[u] <= bif.wr_data[ACT_BIT];
        end else if (bif.pwr_wr && PWR_MASK[u]) begin
          bif.act[u] <= bif.pwr_data[u];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        bif.base_hi[u] <= BASE_RST;
        bif.base_lo[u] <= BASE_RST;
        bif.irq_pri[u] <= IRQ_SEL_RST;
        bif.irq_sec[u] <= IRQ_SEL_RST;
        bif.dma[u] <= DMA_SEL_RST;
      end
    end else begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (bif.wr_unit == u[2:0]) begin
          if (wr_bhi) bif.base_hi[u] <= bif.wr_data;
          if (wr_blo) bif.base_lo[u] <= bif.wr_data;
          if (wr_ip) bif.irq_pri[u] <= bif.wr_data;
          if (wr_is) bif.irq_sec[u] <= bif.wr_data;
          if (wr_dma) bif.dma[u] <= bif.wr_data;
        end
      end
    end
  end
endmodule : unit_bank_store

//--- tb/host_cfg_model.sv
// host configuration software model driving the index and data ports
`timescale 1ns/1ps
module host_cfg_model
  import ldcfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [7:0] io_rdata_i,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic io_data_sel_o,
  output logic [7:0] io_wdata_o
);
  logic [7:0] last_wdata;

  initial begin
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_data_sel_o = 1'b0;
    io_wdata_o = 8'hFF;
    last_wdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // port cycles
  // ----------------------------------------------------------------
  // idle data bus shows the inverse so a stale byte never matches
  task automatic port_wr(input logic sel, input logic [7:0] data);
    @(posedge sys_clk_i);
    io_wr_o <= 1'b1;
    io_data_sel_o <= sel;
    io_wdata_o <= data;
    last_wdata = data;
    @(posedge sys_clk_i);
    io_wr_o <= 1'b0;
    io_wdata_o <= ~last_wdata;
  endtask : port_wr

  task automatic port_rd(input logic sel, output logic [7:0] data);
    @(posedge sys_clk_i);
    io_rd_o <= 1'b1;
    io_data_sel_o <= sel;
    @(posedge sys_clk_i);
    io_rd_o <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    data = io_rdata_i;
  endtask : port_rd

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] data);
    port_wr(1'b0, idx);
    port_wr(1'b1, data);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] data);
    port_wr(1'b0, idx);
    port_rd(1'b1, data);
  endtask : reg_rd

  // the bank is only touched after its unit has been selected
  task automatic unit_sel(input logic [7:0] unit);
    reg_wr(IDX_UNIT_SEL, unit);
  endtask : unit_sel
endmodule : host_cfg_model

//--- tb/logical_device_config_bank_tb_top.sv
// self-checking testbench for the unit configuration bank
`timescale 1ns/1ps
module logical_device_config_bank_tb_top;
  import ldcfg_pkg::*;
  logic sys_clk;
  logic sys_rst;
  logic cfg_state;
  logic io_wr;
  logic io_rd;
  logic io_data_sel;
  logic [7:0] io_wdata;
  logic [7:0] ec_disable;
  logic [7:0] io_rdata;
  logic [NUM_UNITS-1:0] unit_on;
  logic [NUM_UNITS-1:0] decode_en;
  int errors;
  int cmp_count;
  logic [7:0] rv;
  logic [7:0] rsv [13] = '{8'h31, 8'h3F, 8'h40, 8'h5F, 8'h62, 8'h6F, 8'h71,
                           8'h73, 8'h75, 8'h76, 8'hA8, 8'hA9, 8'hDF};

  logical_device_config_bank i_dut (
    .sys_clk_i(sys_clk),
    .sys_rst_i(sys_rst),
    .cfg_state_i(cfg_state),
    .io_wr_i(io_wr),
    .io_rd_i(io_rd),
    .io_data_sel_i(io_data_sel),
    .io_wdata_i(io_wdata),
    .ec_disable_i(ec_disable),
    .io_rdata_o(io_rdata),
    .unit_on_o(unit_on),
    .decode_en_o(decode_en)
  );

  host_cfg_model i_host (
    .sys_clk_i(sys_clk),
    .io_rdata_i(io_rdata),
    .io_wr_o(io_wr),
    .io_rd_o(io_rd),
    .io_data_sel_o(io_data_sel),
    .io_wdata_o(io_wdata)
  );

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    i_host.reg_rd(idx, v);
    chk(v, exp);
  endtask : rchk

  // override changes cross four stages before gating; eight edges leave margin
  task automatic onchk(input logic [7:0] exp_on, input logic [7:0] exp_dec);
    repeat (8) @(posedge sys_clk);
    #1;
    chk(unit_on, exp_on);
    chk(decode_en, exp_dec);
  endtask : onchk

  task automatic set_ec(input logic [7:0] v);
    @(posedge sys_clk);
    ec_disable <= v;
  endtask : set_ec

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    cfg_state = 1'b1;
    ec_disable = 8'hD0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    onchk(8'h00, 8'h00);
    rchk(IDX_UNIT_SEL, 8'h00);
    i_host.unit_sel(8'h05);
    rchk(IDX_IRQ_PRI, IRQ_SEL_RST);
    // program three units with distinct values
    i_host.unit_sel(8'h00);
    i_host.reg_wr(IDX_BASE_HI, 8'h03);
    i_host.reg_wr(IDX_BASE_LO, 8'hF0);
    i_host.reg_wr(IDX_ACTIVATE, 8'h01);
    i_host.reg_wr(IDX_DMA_SEL, 8'h01);
    i_host.reg_wr(IDX_IRQ_SEC, 8'h09);
    i_host.unit_sel(8'h04);
    i_host.reg_wr(IDX_BASE_HI, 8'h02);
    i_host.reg_wr(IDX_BASE_LO, 8'hF8);
    i_host.reg_wr(IDX_ACTIVATE, 8'h01);
    i_host.reg_wr(IDX_IRQ_PRI, 8'h05);
    i_host.reg_wr(IDX_DMA_SEL, 8'h02);
    i_host.reg_wr(IDX_IRQ_SEC, 8'h09);
    i_host.unit_sel(8'h03);
    i_host.reg_wr(IDX_BASE_HI, 8'h0F);
    i_host.reg_wr(IDX_BASE_LO, 8'hFC);
    i_host.reg_wr(IDX_ACTIVATE, 8'h01);
    i_host.reg_wr(IDX_DMA_SEL, 8'h03);
    rchk(IDX_DMA_SEL, 8'h03);
    i_host.unit_sel(8'h00);
    rchk(IDX_BASE_HI, 8'h03);
    rchk(IDX_BASE_LO, 8'hF0);
    rchk(IDX_DMA_SEL, 8'h01);
    rchk(IDX_IRQ_SEC, 8'h00);
    for (int i = 0; i < 13; i++) begin
      i_host.reg_wr(rsv[i], 8'hFF);
      rchk(rsv[i], 8'h00);
    end
    i_host.unit_sel(8'h04);
    rchk(IDX_BASE_HI, 8'h02);
    rchk(IDX_IRQ_PRI, 8'h05);
    rchk(IDX_DMA_SEL, 8'h00);
    rchk(IDX_IRQ_SEC, 8'h00);
    i_host.unit_sel(8'h07);
    i_host.reg_wr(IDX_IRQ_SEC, 8'h0A);
    rchk(IDX_IRQ_SEC, 8'h0A);
    i_host.unit_sel(8'h01);
    i_host.reg_wr(IDX_BASE_HI, 8'hAA);
    rchk(IDX_BASE_HI, 8'h00);
    // power gating through activate, power register and overrides
    onchk(8'h19, 8'h19);
    rchk(IDX_PWR_CTRL, 8'h19);
    set_ec(8'h50);
    onchk(8'h11, 8'h11);
    set_ec(8'h10);
    onchk(8'h01, 8'h01);
    set_ec(8'h00);
    onchk(8'h00, 8'h00);
    set_ec(8'hD0);
    onchk(8'h19, 8'h19);
    i_host.reg_wr(IDX_PWR_CTRL, 8'h08);
    onchk(8'h08, 8'h08);
    i_host.unit_sel(8'h00);
    rchk(IDX_ACTIVATE, 8'h00);
    i_host.reg_wr(IDX_ACTIVATE, 8'h01);
    rchk(IDX_PWR_CTRL, 8'h09);
    // base address misaligned or out of the permitted range
    i_host.reg_wr(IDX_BASE_LO, 8'hF4);
    onchk(8'h09, 8'h08);
    i_host.reg_wr(IDX_BASE_LO, 8'hF0);
    i_host.reg_wr(IDX_BASE_HI, 8'h00);
    onchk(8'h09, 8'h08);
    i_host.reg_wr(IDX_BASE_HI, 8'h03);
    onchk(8'h09, 8'h09);
    i_host.unit_sel(8'h03);
    i_host.reg_wr(IDX_ACTIVATE, 8'h00);
    onchk(8'h01, 8'h01);
    // run state refuses bank writes
    i_host.unit_sel(8'h00);
    @(posedge sys_clk);
    cfg_state <= 1'b0;
    i_host.reg_wr(IDX_BASE_HI, 8'h55);
    rchk(IDX_BASE_HI, 8'h00);
    @(posedge sys_clk);
    cfg_state <= 1'b1;
    rchk(IDX_BASE_HI, 8'h03);
    // only the keyboard unit's window answers in the run state
    i_host.unit_sel(8'h07);
    @(posedge sys_clk);
    cfg_state <= 1'b0;
    rchk(8'h85, 8'h00);
    i_host.reg_wr(IDX_IRQ_SEC, 8'h33);
    @(posedge sys_clk);
    cfg_state <= 1'b1;
    rchk(IDX_IRQ_SEC, 8'h0A);
    i_host.port_wr(1'b0, IDX_BASE_LO);
    i_host.port_rd(1'b0, rv);
    chk(rv, IDX_BASE_LO);
    summarize();
  end
endmodule : logical_device_config_bank_tb_top
